// *** hdl/asu_pkg.sv ***
// Behaviour
// - Data location has separate transmit and receive holding registers; writes never read back
// - Transmit holding feeds output shifter; completed input shifter loads receive holding unless receive-ready is still set
// - Rate register bits 7:6 divide bus clock by 1, 3, 4 or 13
// - Rate register bits 5:3 divide prescaled clock by two to that power for transmit
// - Rate register bits 2:0 divide prescaled clock by two to that power for receive
// - Nonzero receive extended prescaler further divides receive rate by its value
// - Nonzero transmit extended prescaler further divides transmit rate by its value
// - Both extended prescalers reset to zero, so only the conventional divider applies
// - Registers decode at indices 50h to 55h and 57h to 5Ah
// - Transmit-empty clears after status access then data write; no load while set
// - Receive-ready and receive errors clear after status read then data read
package asu_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_STATUS = 8'h50;
   localparam logic [7:0] IDX_DATA = 8'h51;
   localparam logic [7:0] IDX_RATE = 8'h52;
   localparam logic [7:0] IDX_FRAME = 8'h53;
   localparam logic [7:0] IDX_CTRL2 = 8'h54;
   localparam logic [7:0] IDX_RX_EXT = 8'h55;
   localparam logic [7:0] IDX_TX_EXT = 8'h57;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h58;
   localparam logic [7:0] IDX_IRQ_CLR = 8'h59;
   localparam logic [7:0] IDX_IRQ_EN = 8'h5A;

   // Rate register fields
   localparam int RATE_PRE_HI = 7;
   localparam int RATE_PRE_LO = 6;
   localparam int RATE_TX_HI = 5;
   localparam int RATE_TX_LO = 3;
   localparam int RATE_RX_HI = 2;
   localparam int RATE_RX_LO = 0;

   // Status bit positions
   localparam int ST_TX_EMPTY = 7;
   localparam int ST_TX_DONE = 6;
   localparam int ST_RX_READY = 5;
   localparam int ST_OVERRUN = 3;
   localparam int ST_FRAME_ERR = 1;

   // Control bit positions
   localparam int FRAME_DISABLE = 5;
   localparam int CTRL2_TX_EN = 3;
   localparam int CTRL2_RX_EN = 2;

   // Reset values
   localparam logic [7:0] STATUS_RST = 8'hC0;
   localparam logic [7:0] RATE_RST = 8'h00;
   localparam logic [7:0] FRAME_RST = 8'h00;
   localparam logic [7:0] CTRL2_RST = 8'h00;
   localparam logic [7:0] EXT_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;

   // Interrupt event bits
   localparam int EV_TX_EMPTY = 0;
   localparam int EV_TX_DONE = 1;
   localparam int EV_RX_READY = 2;
   localparam int EV_OVERRUN = 3;
   localparam int EV_FRAME_ERR = 4;
   localparam int EV_W = 5;

   // Oversampling per bit and sample points
   localparam logic [3:0] OS_LAST = 4'hF;
   localparam logic [3:0] OS_MID = 4'h7;
   localparam logic [2:0] BIT_LAST = 3'h7;

   typedef enum logic [3:0] {
      TX_IDLE = 4'b0001,
      TX_START = 4'b0010,
      TX_DATA = 4'b0100,
      TX_STOP = 4'b1000
   } asu_tx_state_t;

   typedef enum logic [3:0] {
      RX_IDLE = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA = 4'b0100,
      RX_STOP = 4'b1000
   } asu_rx_state_t;

   // First prescaler terminal count: factor 1, 3, 4 or 13, minus one
   function automatic logic [3:0] pre_limit(input logic [1:0] sel);
      case (sel)
         2'h0: pre_limit = 4'h0;
         2'h1: pre_limit = 4'h2;
         2'h2: pre_limit = 4'h3;
         default: pre_limit = 4'hC;
      endcase
   endfunction

endpackage

// *** hdl/asu_rate_gen.sv ***
`timescale 1ns/1ps
module asu_rate_gen
   import asu_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Configuration
   input wire logic en_i,
   input wire logic [1:0] pre_sel_i,
   input wire logic [2:0] div_sel_i,
   input wire logic [7:0] ext_i,
   // Sixteen-times bit rate tick
   output logic os_tick_o
);

   logic [3:0] pre_cnt_r;
   logic [3:0] pre_cnt_nxt;
   logic [6:0] div_cnt_r;
   logic [6:0] div_cnt_nxt;
   logic [7:0] ext_cnt_r;
   logic [7:0] ext_cnt_nxt;
   logic tick_r;
   logic tick_nxt;
   logic pre_tick;
   logic rate_tick;
   logic [7:0] pow;
   logic [6:0] div_lim;

   always_comb
   begin
      pre_tick = en_i && (pre_cnt_r >= pre_limit(pre_sel_i));
      pre_cnt_nxt = (!en_i || pre_tick) ? 4'h0 : pre_cnt_r + 4'h1;
      // power-of-two divisor; >= keeps a lowered limit safe
      pow = 8'h01 << div_sel_i;
      div_lim = 7'(pow - 8'h01);
      rate_tick = pre_tick && (div_cnt_r >= div_lim);
      div_cnt_nxt = div_cnt_r;
      if (!en_i || rate_tick)
         div_cnt_nxt = 7'h00;
      else if (pre_tick)
         div_cnt_nxt = div_cnt_r + 7'h01;
      // extended prescaler, bypassed at zero; same rate as after the power-of-two stage
      ext_cnt_nxt = ext_cnt_r;
      if (ext_i == 8'h00)
      begin
         tick_nxt = rate_tick;
         ext_cnt_nxt = 8'h00;
      end
      else
      begin
         tick_nxt = rate_tick && (ext_cnt_r >= ext_i - 8'h01);
         if (!en_i || tick_nxt)
            ext_cnt_nxt = 8'h00;
         else if (rate_tick)
            ext_cnt_nxt = ext_cnt_r + 8'h01;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pre_cnt_r <= 4'h0;
         div_cnt_r <= 7'h00;
         ext_cnt_r <= 8'h00;
         tick_r <= 1'b0;
      end
      else
      begin
         pre_cnt_r <= pre_cnt_nxt;
         div_cnt_r <= div_cnt_nxt;
         ext_cnt_r <= ext_cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign os_tick_o = tick_r;

   a_pre_div4: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (pre_tick && en_i && pre_sel_i == 2'h2) ##1 (en_i && pre_sel_i == 2'h2) [*4]
         |-> pre_tick && !$past(pre_tick) && !$past(pre_tick, 2) && !$past(pre_tick, 3))
      else $error("prescale by four spacing wrong");
   // A lowered limit may leave the counter above it until the next prescaler tick
   a_div_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (en_i && div_cnt_r <= div_lim) ##1 $stable(div_sel_i) |-> div_cnt_r <= div_lim)
      else $error("rate divisor counter past its limit");
   a_ext_bypass: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ext_i == 8'h00) |=> os_tick_o == $past(rate_tick))
      else $error("zero extended prescaler not bypassed");
   a_ext_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (ext_i != 8'h00 && ext_cnt_r < ext_i) ##1 $stable(ext_i) |-> ext_cnt_r < ext_i)
      else $error("extended prescaler counter past its value");

endmodule

// *** hdl/asu_sync.sv ***
`timescale 1ns/1ps
module asu_sync
   import asu_pkg::*;
#(
   parameter logic RST_VAL = 1'b1
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Level
   input wire logic d_i,
   output logic q_o
);

   logic meta_r;
   logic q_r;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta_r <= RST_VAL;
         q_r <= RST_VAL;
      end
      else
      begin
         meta_r <= d_i;
         q_r <= meta_r;
      end
   end

   assign q_o = q_r;

endmodule

// *** hdl/asu_top.sv ***
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
module asu_top
   import asu_pkg::*;
(
   // Clock and reset
   input wire logic CLK_SYS_I,
   input wire logic ARST_N_I,
   // Wishbone slave
   input wire logic [9:0] ADR_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   input wire logic [3:0] SEL_I,
   input wire logic WE_I,
   input wire logic CYC_I,
   input wire logic STB_I,
   output logic ACK_O,
   // Serial line
   input wire logic RXD_I,
   output logic TXD_O,
   // Interrupt
   output logic IRQ_O
);

   logic rst_meta_r;
   logic rst_n;
   logic rxd_s;
   logic tx_os;
   logic rx_os;

   always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   // Register state
   logic ack_r, ack_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic [7:0] tx_hold_r, tx_hold_nxt;
   logic [7:0] rx_hold_r, rx_hold_nxt;
   logic [7:0] rate_r, rate_nxt;
   logic [7:0] frame_r, frame_nxt;
   logic [7:0] ctrl2_r, ctrl2_nxt;
   logic [7:0] rx_ext_r, rx_ext_nxt;
   logic [7:0] tx_ext_r, tx_ext_nxt;
   logic tx_empty_r, tx_empty_nxt;
   logic tx_done_r, tx_done_nxt;
   logic rx_ready_r, rx_ready_nxt;
   logic ovr_r, ovr_nxt;
   logic fe_r, fe_nxt;
   logic tx_arm_r, tx_arm_nxt;
   logic rx_arm_r, rx_arm_nxt;
   logic [EV_W-1:0] irq_stat_r, irq_stat_nxt;
   logic [EV_W-1:0] irq_en_r, irq_en_nxt;
   logic irq_r, irq_nxt;
   // Transmit state
   asu_tx_state_t tx_st_r, tx_st_nxt;
   logic [3:0] tx_os_r, tx_os_nxt;
   logic [2:0] tx_bit_r, tx_bit_nxt;
   logic [7:0] tx_sh_r, tx_sh_nxt;
   logic txd_r, txd_nxt;
   // Receive state
   asu_rx_state_t rx_st_r, rx_st_nxt;
   logic [3:0] rx_os_r, rx_os_nxt;
   logic [2:0] rx_bit_r, rx_bit_nxt;
   logic [7:0] rx_sh_r, rx_sh_nxt;

   logic req, wr, rd;
   logic [7:0] idx;
   logic [7:0] status;
   logic [7:0] rd_mux;
   logic tx_load, tx_end, rx_end, rx_stop_ok;
   logic [EV_W-1:0] ev;

   asu_sync #(.RST_VAL(1'b1)) u_rx_sync (
      .clk_i(CLK_SYS_I),
      .rst_n_i(rst_n),
      .d_i(RXD_I),
      .q_o(rxd_s)
   );

   asu_rate_gen u_tx_rate (
      .clk_i(CLK_SYS_I),
      .rst_n_i(rst_n),
      .en_i(!frame_r[FRAME_DISABLE]),
      .pre_sel_i(rate_r[RATE_PRE_HI:RATE_PRE_LO]),
      .div_sel_i(rate_r[RATE_TX_HI:RATE_TX_LO]),
      .ext_i(tx_ext_r),
      .os_tick_o(tx_os)
   );

   asu_rate_gen u_rx_rate (
      .clk_i(CLK_SYS_I),
      .rst_n_i(rst_n),
      .en_i(!frame_r[FRAME_DISABLE]),
      .pre_sel_i(rate_r[RATE_PRE_HI:RATE_PRE_LO]),
      .div_sel_i(rate_r[RATE_RX_HI:RATE_RX_LO]),
      .ext_i(rx_ext_r),
      .os_tick_o(rx_os)
   );

   assign req = CYC_I && STB_I && !ack_r;
   assign idx = ADR_I[9:2];
   assign wr = req && WE_I && SEL_I[0];
   assign rd = req && !WE_I;
   assign status = {tx_empty_r, tx_done_r, rx_ready_r, 1'b0, ovr_r, 1'b0, fe_r, 1'b0};

   // Register file, bus answer, flags and interrupt
   always_comb
   begin
      ack_nxt = req;
      tx_hold_nxt = tx_hold_r;
      rx_hold_nxt = rx_hold_r;
      rate_nxt = rate_r;
      frame_nxt = frame_r;
      ctrl2_nxt = ctrl2_r;
      rx_ext_nxt = rx_ext_r;
      tx_ext_nxt = tx_ext_r;
      tx_empty_nxt = tx_empty_r;
      tx_done_nxt = tx_done_r;
      rx_ready_nxt = rx_ready_r;
      ovr_nxt = ovr_r;
      fe_nxt = fe_r;
      tx_arm_nxt = tx_arm_r;
      rx_arm_nxt = rx_arm_r;
      irq_en_nxt = irq_en_r;
      irq_stat_nxt = irq_stat_r;
      ev = '0;
      case (idx)
         IDX_STATUS: rd_mux = status;
         // reads return only the receive holding register
         IDX_DATA: rd_mux = rx_hold_r;
         IDX_RATE: rd_mux = rate_r;
         IDX_FRAME: rd_mux = frame_r;
         IDX_CTRL2: rd_mux = ctrl2_r;
         IDX_RX_EXT: rd_mux = rx_ext_r;
         IDX_TX_EXT: rd_mux = tx_ext_r;
         IDX_IRQ_STAT: rd_mux = {3'h0, irq_stat_r};
         IDX_IRQ_EN: rd_mux = {3'h0, irq_en_r};
         default: rd_mux = 8'h00;
      endcase
      dat_nxt = rd ? {24'h000000, rd_mux} : 32'h00000000;
      if (wr)
      begin
         case (idx)
            // writes land only in the transmit holding register
            IDX_DATA: tx_hold_nxt = DAT_I[7:0];
            IDX_RATE: rate_nxt = DAT_I[7:0];
            IDX_FRAME: frame_nxt = DAT_I[7:0];
            IDX_CTRL2: ctrl2_nxt = DAT_I[7:0];
            IDX_RX_EXT: rx_ext_nxt = DAT_I[7:0];
            IDX_TX_EXT: tx_ext_nxt = DAT_I[7:0];
            IDX_IRQ_CLR: irq_stat_nxt = irq_stat_r & ~DAT_I[EV_W-1:0];
            IDX_IRQ_EN: irq_en_nxt = DAT_I[EV_W-1:0];
            default: ;
         endcase
      end
      // status access then data write clears transmit flags
      if (req && idx == IDX_STATUS)
         tx_arm_nxt = 1'b1;
      if (wr && idx == IDX_DATA && tx_arm_r)
      begin
         tx_empty_nxt = 1'b0;
         tx_done_nxt = 1'b0;
         tx_arm_nxt = 1'b0;
      end
      // status read then data read clears receive flags
      if (rd && idx == IDX_STATUS)
         rx_arm_nxt = 1'b1;
      if (rd && idx == IDX_DATA && rx_arm_r)
      begin
         rx_ready_nxt = 1'b0;
         ovr_nxt = 1'b0;
         fe_nxt = 1'b0;
         rx_arm_nxt = 1'b0;
      end
      // Hardware sets win over the software clears above, except transmit-done, whose set needs transmit-empty to stay set
      if (tx_load)
      begin
         tx_empty_nxt = 1'b1;
         ev[EV_TX_EMPTY] = 1'b1;
      end
      if (tx_end && tx_empty_nxt)
      begin
         tx_done_nxt = 1'b1;
         ev[EV_TX_DONE] = 1'b1;
      end
      // completed character loads the receive holding register unless it is still full
      if (rx_end)
      begin
         if (rx_ready_nxt)
         begin
            ovr_nxt = 1'b1;
            ev[EV_OVERRUN] = 1'b1;
         end
         else
         begin
            rx_hold_nxt = rx_sh_r;
            rx_ready_nxt = 1'b1;
            ev[EV_RX_READY] = 1'b1;
            if (!rx_stop_ok)
            begin
               fe_nxt = 1'b1;
               ev[EV_FRAME_ERR] = 1'b1;
            end
         end
      end
      irq_stat_nxt = irq_stat_nxt | ev;
      irq_nxt = |(irq_stat_r & irq_en_r);
   end

   always_ff @(posedge CLK_SYS_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_r <= 1'b0;
         dat_r <= 32'h00000000;
         tx_hold_r <= DATA_RST;
         rx_hold_r <= DATA_RST;
         rate_r <= RATE_RST;
         frame_r <= FRAME_RST;
         ctrl2_r <= CTRL2_RST;
         rx_ext_r <= EXT_RST;
         tx_ext_r <= EXT_RST;
         tx_empty_r <= STATUS_RST[ST_TX_EMPTY];
         tx_done_r <= STATUS_RST[ST_TX_DONE];
         rx_ready_r <= STATUS_RST[ST_RX_READY];
         ovr_r <= STATUS_RST[ST_OVERRUN];
         fe_r <= STATUS_RST[ST_FRAME_ERR];
         tx_arm_r <= 1'b0;
         rx_arm_r <= 1'b0;
         irq_stat_r <= '0;
         irq_en_r <= '0;
         irq_r <= 1'b0;
      end
      else
      begin
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
         tx_hold_r <= tx_hold_nxt;
         rx_hold_r <= rx_hold_nxt;
         rate_r <= rate_nxt;
         frame_r <= frame_nxt;
         ctrl2_r <= ctrl2_nxt;
         rx_ext_r <= rx_ext_nxt;
         tx_ext_r <= tx_ext_nxt;
         tx_empty_r <= tx_empty_nxt;
         tx_done_r <= tx_done_nxt;
         rx_ready_r <= rx_ready_nxt;
         ovr_r <= ovr_nxt;
         fe_r <= fe_nxt;
         tx_arm_r <= tx_arm_nxt;
         rx_arm_r <= rx_arm_nxt;
         irq_stat_r <= irq_stat_nxt;
         irq_en_r <= irq_en_nxt;
         irq_r <= irq_nxt;
      end
   end

   // load only while the holding register is full; a data write blocks it
   assign tx_load = (tx_st_r == TX_IDLE) && !tx_empty_r && ctrl2_r[CTRL2_TX_EN]
      && !(wr && idx == IDX_DATA);
   assign tx_end = (tx_st_r == TX_STOP) && tx_os && (tx_os_r == OS_LAST);

   // Transmitter: start, eight data bits LSB first, stop; sixteen ticks per bit
   always_comb
   begin
      tx_st_nxt = tx_st_r;
      tx_os_nxt = tx_os_r;
      tx_bit_nxt = tx_bit_r;
      tx_sh_nxt = tx_sh_r;
      txd_nxt = txd_r;
      if (tx_st_r != TX_IDLE && tx_os)
         tx_os_nxt = tx_os_r + 4'h1;
      case (tx_st_r)
         TX_IDLE:
         begin
            // holding register hands its byte to the shifter
            if (tx_load)
            begin
               tx_sh_nxt = tx_hold_r;
               tx_os_nxt = 4'h0;
               tx_bit_nxt = 3'h0;
               txd_nxt = 1'b0;
               tx_st_nxt = TX_START;
            end
         end
         TX_START:
         begin
            if (tx_os && tx_os_r == OS_LAST)
            begin
               txd_nxt = tx_sh_r[0];
               tx_st_nxt = TX_DATA;
            end
         end
         TX_DATA:
         begin
            if (tx_os && tx_os_r == OS_LAST)
            begin
               tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
               tx_bit_nxt = tx_bit_r + 3'h1;
               txd_nxt = (tx_bit_r == BIT_LAST) ? 1'b1 : tx_sh_r[1];
               if (tx_bit_r == BIT_LAST)
                  tx_st_nxt = TX_STOP;
            end
         end
         TX_STOP:
         begin
            if (tx_end)
               tx_st_nxt = TX_IDLE;
         end
         default: tx_st_nxt = TX_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_st_r <= TX_IDLE;
         tx_os_r <= 4'h0;
         tx_bit_r <= 3'h0;
         tx_sh_r <= 8'h00;
         txd_r <= 1'b1;
      end
      else
      begin
         tx_st_r <= tx_st_nxt;
         tx_os_r <= tx_os_nxt;
         tx_bit_r <= tx_bit_nxt;
         tx_sh_r <= tx_sh_nxt;
         txd_r <= txd_nxt;
      end
   end

   assign rx_end = (rx_st_r == RX_STOP) && rx_os && (rx_os_r == OS_LAST);
   assign rx_stop_ok = rxd_s;

   // Receiver: start bit checked at mid point, bits sampled sixteen ticks apart
   always_comb
   begin
      rx_st_nxt = rx_st_r;
      rx_os_nxt = rx_os_r;
      rx_bit_nxt = rx_bit_r;
      rx_sh_nxt = rx_sh_r;
      if (rx_st_r != RX_IDLE && rx_os)
         rx_os_nxt = rx_os_r + 4'h1;
      case (rx_st_r)
         RX_IDLE:
         begin
            rx_os_nxt = 4'h0;
            rx_bit_nxt = 3'h0;
            if (ctrl2_r[CTRL2_RX_EN] && !rxd_s)
               rx_st_nxt = RX_START;
         end
         RX_START:
         begin
            if (rx_os && rx_os_r == OS_MID)
            begin
               rx_os_nxt = 4'h0;
               rx_st_nxt = rxd_s ? RX_IDLE : RX_DATA;
            end
         end
         RX_DATA:
         begin
            if (rx_os && rx_os_r == OS_LAST)
            begin
               rx_sh_nxt = {rxd_s, rx_sh_r[7:1]};
               rx_bit_nxt = rx_bit_r + 3'h1;
               if (rx_bit_r == BIT_LAST)
                  rx_st_nxt = RX_STOP;
            end
         end
         RX_STOP:
         begin
            if (rx_end)
               rx_st_nxt = RX_IDLE;
         end
         default: rx_st_nxt = RX_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_st_r <= RX_IDLE;
         rx_os_r <= 4'h0;
         rx_bit_r <= 3'h0;
         rx_sh_r <= 8'h00;
      end
      else
      begin
         rx_st_r <= rx_st_nxt;
         rx_os_r <= rx_os_nxt;
         rx_bit_r <= rx_bit_nxt;
         rx_sh_r <= rx_sh_nxt;
      end
   end

   assign ACK_O = ack_r;
   assign DAT_O = dat_r;
   assign TXD_O = txd_r;
   assign IRQ_O = irq_r;

   a_data_readback: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
      (rd && idx == IDX_DATA && !rx_end) |=> DAT_O[7:0] == rx_hold_r)
      else $error("data read did not return receive holding register");
   a_tx_handoff: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
      tx_load |=> (tx_sh_r == $past(tx_hold_r)) && !TXD_O && tx_empty_r)
      else $error("transmit byte not handed to shifter");
   a_ext_reset: assert property (@(posedge CLK_SYS_I)
      $rose(rst_n) |-> (rx_ext_r == 8'h00) && (tx_ext_r == 8'h00))
      else $error("extended prescalers not zero after reset");
   a_rate_decode: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
      (rd && idx == IDX_RATE) |=> ACK_O && DAT_O == {24'h000000, rate_r})
      else $error("rate register read wrong");
   a_tx_empty_clear: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
      $fell(tx_empty_r) |-> $past(wr && idx == IDX_DATA && tx_arm_r))
      else $error("transmit-empty cleared without status then data write");
   a_rx_ready_clear: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
      $fell(rx_ready_r) |-> $past(rd && idx == IDX_DATA && rx_arm_r) && !ovr_r && !fe_r)
      else $error("receive flags cleared without status then data read");
   a_bit_length: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
      (tx_st_r == TX_DATA && tx_os && tx_os_r == OS_LAST) |=> tx_os_r == 4'h0)
      else $error("transmit bit not sixteen ticks long");
   a_rate_keeps_regs: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
      (wr && idx == IDX_RATE) |=> $stable(tx_hold_r) && $stable(rx_ext_r)
         && $stable(tx_ext_r))
      else $error("rate write disturbed other registers");
   a_bus_answer: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
      (CYC_I && STB_I && !ACK_O) |=> ACK_O ##1 !ACK_O)
      else $error("bus answer not one cycle after request");

endmodule

// *** sim/asu_remote.sv ***
`timescale 1ns/1ps
module asu_remote
(
   // Clock
   input wire logic clk_i,
   // Serial line
   input wire logic txd_i,
   output logic rxd_o,
   // Bit length in clocks
   input wire logic [31:0] bit_clk_i
);
   logic [8:0] got_q[$];
   logic [8:0] sh;
   initial rxd_o = 1'b1;
   always @(negedge txd_i)
   begin
      repeat (bit_clk_i / 2) @(posedge clk_i);
      for (int k = 0; k < 9; k++)
      begin
         repeat (bit_clk_i) @(posedge clk_i);
         sh = {txd_i, sh[8:1]};
      end
      got_q.push_back(sh);
   end
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int k = 0; k < 10; k++)
      begin
         rxd_o <= f[k];
         repeat (bit_clk_i) @(posedge clk_i);
      end
   endtask
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb;
   import asu_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [9:0] adr = '0;
   logic [31:0] dat_w = '0;
   logic [31:0] dat_r;
   logic [3:0] sel = '0;
   logic we = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic ack, rxd, txd, irq;
   int bit_clk = 16;
   int n_fail = 0;
   int num_checks = 0;
   logic [31:0] seed = 32'hCA44;
   logic [7:0] mdl [logic [7:0]];
   logic [7:0] q, b;
   logic [8:0] f;
   logic [7:0] tx_rate [5] = '{8'h40, 8'hC8, 8'h98, 8'h00, 8'h18};
   logic [7:0] tx_ext [5] = '{8'h00, 8'h00, 8'h00, 8'h23, 8'h02};
   logic [7:0] rx_rate [3] = '{8'h01, 8'h42, 8'hC0};
   logic [7:0] rx_ext [3] = '{8'h00, 8'h00, 8'h03};

   always #10 clk = ~clk;

   asu_top i_dut (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .ADR_I(adr), .DAT_I(dat_w),
      .DAT_O(dat_r), .SEL_I(sel), .WE_I(we), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack),
      .RXD_I(rxd), .TXD_O(txd), .IRQ_O(irq));
   asu_remote i_rem (.clk_i(clk), .txd_i(txd), .rxd_o(rxd), .bit_clk_i(bit_clk));

   function automatic logic [7:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction
   function automatic int rate_clk(input logic [2:0] dv, input logic [1:0] ps,
      input logic [7:0] ext);
      int pr [4] = '{1, 3, 4, 13};
      return 16 * pr[ps] * (1 << dv) * ((ext == 8'h00) ? 1 : int'(ext));
   endfunction
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic give_up();
      n_fail++;
      close_out();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      adr <= {idx, 2'h0};
      dat_w <= {24'h0, d};
      we <= w;
      sel <= 4'hF;
      cyc <= 1'b1;
      stb <= 1'b1;
      @(posedge clk);
      while (ack !== 1'b1)
      begin
         n++;
         if (n > 20)
            give_up();
         @(posedge clk);
      end
      q = dat_r[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(idx, 1'b1, d);
      if (mdl.exists(idx))
         mdl[idx] = d;
   endtask
   task automatic frame(input logic [7:0] e);
      int n;
      n = 0;
      while (i_rem.got_q.size() == 0)
      begin
         @(posedge clk);
         n++;
         if (n > 20000)
            give_up();
      end
      f = i_rem.got_q.pop_front();
      chk({23'h0, f}, {23'h0, 1'b1, e});
      repeat (bit_clk) @(posedge clk);
      bus(IDX_STATUS, 1'b0, 8'h00);
      chk(q, STATUS_RST);
   endtask

   initial
   begin
      mdl[IDX_STATUS] = STATUS_RST;
      mdl[IDX_IRQ_STAT] = 8'h00;
      mdl[IDX_RATE] = RATE_RST;
      mdl[IDX_FRAME] = FRAME_RST;
      mdl[IDX_CTRL2] = CTRL2_RST;
      mdl[IDX_RX_EXT] = EXT_RST;
      mdl[IDX_TX_EXT] = EXT_RST;
      mdl[IDX_IRQ_EN] = 8'h00;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      foreach (mdl[i])
      begin
         bus(i, 1'b0, 8'h00);
         chk(q, mdl[i]);
      end
      foreach (mdl[i])
         if (i != IDX_STATUS && i != IDX_IRQ_STAT)
         begin
            b = rnd() & ((i == IDX_IRQ_EN) ? 8'h13 : 8'hD3);
            wr(i, b);
            bus(i, 1'b0, 8'h00);
            chk(q, b);
         end
      wr(IDX_RATE, 8'h00);
      wr(IDX_RX_EXT, 8'h00);
      wr(IDX_TX_EXT, 8'h00);
      wr(IDX_CTRL2, 8'h00);
      wr(IDX_IRQ_EN, 8'h00);
      wr(8'h56, rnd());
      bus(8'h56, 1'b0, 8'h00);
      chk(q, 8'h00);
      // Transmitter disabled: the written byte must wait
      bus(IDX_STATUS, 1'b0, 8'h00);
      b = rnd();
      wr(IDX_DATA, b);
      bus(IDX_DATA, 1'b0, 8'h00);
      chk(q, DATA_RST);
      bus(IDX_STATUS, 1'b0, 8'h00);
      chk(q, 8'h00);
      wr(IDX_CTRL2, 8'h08);
      frame(b);
      for (int k = 0; k < 5; k++)
      begin
         wr(IDX_RATE, tx_rate[k]);
         wr(IDX_TX_EXT, tx_ext[k]);
         bit_clk = rate_clk(tx_rate[k][5:3], tx_rate[k][7:6], tx_ext[k]);
         bus(IDX_STATUS, 1'b0, 8'h00);
         b = rnd();
         wr(IDX_DATA, b);
         frame(b);
      end
      wr(IDX_CTRL2, 8'h0C);
      wr(IDX_IRQ_EN, 8'h04);
      for (int k = 0; k < 3; k++)
      begin
         wr(IDX_RATE, rx_rate[k]);
         wr(IDX_RX_EXT, rx_ext[k]);
         bit_clk = rate_clk(rx_rate[k][2:0], rx_rate[k][7:6], rx_ext[k]);
         b = rnd();
         i_rem.send(b);
         q = 8'h00;
         for (int n = 0; q[ST_RX_READY] !== 1'b1; n++)
         begin
            if (n > 50)
               give_up();
            bus(IDX_STATUS, 1'b0, 8'h00);
         end
         chk({31'h0, irq}, 32'h1);
         bus(IDX_DATA, 1'b0, 8'h00);
         chk(q, b);
         bus(IDX_STATUS, 1'b0, 8'h00);
         chk(q, STATUS_RST);
         wr(IDX_IRQ_CLR, 8'h1F);
         repeat (2) @(posedge clk);
         chk({31'h0, irq}, 32'h0);
      end
      // Second byte lands while the first is unread
      b = rnd();
      i_rem.send(b);
      i_rem.send(rnd());
      wr(IDX_IRQ_EN, 8'h00);
      bus(IDX_STATUS, 1'b0, 8'h00);
      chk(q, 8'hE8);
      chk({31'h0, irq}, 32'h0);
      bus(IDX_DATA, 1'b0, 8'h00);
      chk(q, b);
      bus(IDX_STATUS, 1'b0, 8'h00);
      chk(q, STATUS_RST);
      close_out();
   end
endmodule
